/* test_tuner_output_gain_format.sv */
// Purpose: self-checking bench of the output gain and format stage
// Assumes: apb slave answers within a bounded wait
// Notes: one task per scenario; all expectations are worked out by hand
`timescale 1ns/1ps
module test_tuner_output_gain_format;
  import tgf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sync_n, clr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  tgf_sample_t smp;
  tgf_word_t wo;
  logic ckoff;
  logic [15:0] fi, si;
  int hc, error_cnt = 0, comparisons = 0;
  tgf_top i_tgf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_in(smp), .gain_sync_pin_n(sync_n), .word_out(wo),
    .clock_loss_detect_off(ckoff));
  tgf_sink i_tgf_sink (.pclk(pclk), .clr(clr), .word(wo), .high_cnt(hc), .first_i(fi),
    .second_i(si));
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer; pready and read data are taken at the completing edge itself
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      check(0, 1);
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // bounded wait for a word value on the in-phase port
  task automatic wait_i(input logic [15:0] exp);
    @(negedge pclk);
    for (int n = 0; n < 60 && wo.i !== exp; n++) @(negedge pclk);
    check(wo.i, exp);
    if (wo.i !== exp) test_done();
  endtask : wait_i
  task automatic regs_test;
    apb(0, 12'h018, 0);
    check(rd, 32'h0);
    check(err, 0);
    apb(0, 12'h020, 0);
    check(rd, 32'h80);
    apb(1, 12'h018, 32'ha5);
    apb(0, 12'h018, 0);
    check(rd, 32'ha5);
    apb(1, 12'h01c, 32'hff);
    apb(0, 12'h01c, 0);
    check(rd, 32'h3f);
    check(ckoff, 1);
    apb(1, 12'h01c, 32'h00);
    @(negedge pclk);
    check(ckoff, 0);
    apb(0, 12'h024, 0);
    check(err, 1);
  endtask : regs_test
  // unity, mantissa-only write, sync pin hold and release, saturation
  task automatic gain_test;
    apb(1, 12'h018, 32'h00);
    apb(1, 12'h01c, 32'h06);
    wait_i(16'h1230);
    apb(1, 12'h018, 32'h80);            // mantissa first
    apb(1, 12'h01c, 32'h17);            // then exponent
    repeat (10) @(negedge pclk);
    check(wo.i, 16'h1230);
    @(posedge pclk);
    sync_n <= 0;
    wait_i(16'h3690);
    // mantissa alone while the pin is low: a false pending flag would show here
    apb(1, 12'h018, 32'h00);
    repeat (10) @(negedge pclk);
    check(wo.i, 16'h3690);
    @(posedge pclk);
    sync_n <= 1;
    apb(1, 12'h01c, 32'h07);
    wait_i(16'h2460);
    apb(1, 12'h01c, 32'h0f);
    wait_i(16'h7fff);
    apb(1, 12'h01c, 32'h06);
  endtask : gain_test
  task automatic round_test;
    smp.i <= 12'h127;
    wait_i(16'h1270);
    apb(1, 12'h020, 32'h30);
    wait_i(16'h1280);
    apb(1, 12'h020, 32'h20);            // one rounding bit
    wait_i(16'h1270);
    @(posedge pclk);
    smp.i <= 12'h123;
  endtask : round_test
  // strobe highs over 32 cycles at rate 3: word period 4, interleaved 2
  task automatic strobe_test;
    logic [7:0] f[5] = '{8'h80, 8'h81, 8'h84, 8'h86, 8'h82};
    int e[5] = '{8, 16, 16, 16, 24};
    apb(1, 12'h014, 32'h03);
    apb(1, 12'h01c, 32'h04);            // unity gain at rate 3
    for (int k = 0; k < 5; k++) begin
      apb(1, 12'h020, {24'h0, f[k]});
      repeat (8) @(posedge pclk);
      clr <= 1;
      @(posedge pclk);
      clr <= 0;
      repeat (32) @(posedge pclk);
      @(negedge pclk);
      check(hc, e[k]);
    end
    apb(1, 12'h020, 32'h81);
    repeat (12) @(negedge pclk);
    check(fi, 16'h1230);
    check(si, 16'hf000);
    check(wo.q, 16'h0);
    apb(1, 12'h020, 32'h80);
    repeat (12) @(negedge pclk);
    check(wo.q, 16'hf000);
    apb(1, 12'h014, 32'h13);
    repeat (12) @(negedge pclk);
    check(wo.q, 16'h0);
  endtask : strobe_test
  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    sync_n = 1;
    clr = 0;
    smp = '{valid: 1'b1, i: 12'h123, q: 12'hf00};
    repeat (16) @(posedge pclk);
    presetn <= 1;
    regs_test();
    gain_test();
    round_test();
    strobe_test();
    test_done();
  end
endmodule : test_tuner_output_gain_format

/* tgf_cfg.svh */
// Purpose: constants for the tuner output gain and format stage
// Assumes: registers are word aligned, byte address is four times the index
// Notes: included by the design module only; the package does not use it
// What this block does
// [RULE1] eight-bit gain mantissa register, read/write
// [RULE2] four-bit gain exponent in power bits 0-3
// [RULE3] gain is 2^(exponent-base) times (1+mantissa/256)
// [RULE4] base shift 6 down to 0 by rate
// [RULE5] unity gain puts 12-bit input in top bits
// [RULE6] double buffered gain, exponent write marks pending
// [RULE7] sync select clear: apply right after exponent write
// [RULE8] sync select set: wait for sync pin low
// [RULE9] host writes mantissa first, then exponent always
// [RULE10] power bit 5 disables clock-loss detect, resets low
// [RULE11] interleave clear: separate in-phase and quadrature ports
// [RULE12] interleave set: in-phase then quadrature on one port
// [RULE13] interleaved strobe rate is doubled; at full clock rate the code keeps the one-clock period
// [RULE14] first-half marker flags the in-phase word
// [RULE15] interleaved mode drives quadrature port low
// [RULE16] format bit 1 inverts strobe polarity
// [RULE17] pulse style: strobe high cycle before transition
// [RULE18] clock style: 50% strobe, rising mid-period; at a one-clock period the code keeps the strobe asserted
// [RULE19] format bits 4-7 round to 10/12/14/16 bits
// [RULE20] bits below the rounded width read zero
// [RULE21] host sets exactly one rounding bit
// [RULE22] real-output bit selects real; interleave only complex
// [RULE23] gain result saturates on overflow, always
// [RULE24] several rounding bits: narrowest width wins
// [RULE25] power bits 7:6 read zero, writes ignored
`ifndef TGF_CFG_SVH
`define TGF_CFG_SVH
`define TGF_IDX_MODE 4'h5
`define TGF_IDX_MAN 4'h6
`define TGF_IDX_POW 4'h7
`define TGF_IDX_FMT 4'h8
`define TGF_GS_BIT 4
`define TGF_CKOFF_BIT 5
`define TGF_ILV_BIT 0
`define TGF_POL_BIT 1
`define TGF_STY_BIT 2
`define TGF_RND_LSB 4
`define TGF_REAL_BIT 4
`define TGF_MAN_RST 8'h00
`define TGF_POW_RST 8'h00
`define TGF_FMT_RST 8'h80
`define TGF_MODE_RST 8'h00
`define TGF_BASE_MAX 3'h6
`define TGF_GUARD 4
`define TGF_OUT_W 16
`endif

/* tgf_pkg.sv */
// Purpose: types of the tuner output gain and format stage
// Assumes: nothing beyond the cfg header
// Notes: all state of the top module lives in tgf_state_t
package tgf_pkg;
  typedef struct packed {
    logic valid;
    logic signed [11:0] i;
    logic signed [11:0] q;
  } tgf_sample_t;
  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
    logic strobe;
    logic marker;
  } tgf_word_t;
  typedef struct packed {
    logic [7:0] man;
    logic [7:0] act_man;
    logic [3:0] pow;
    logic [3:0] act_pow;
    logic gs_sel;
    logic ckoff;
    logic pend;
    logic [7:0] fmt;
    logic [2:0] rate;
    logic real_out;
    logic sync1;
    logic sync2;
    logic signed [39:0] wi;
    logic signed [39:0] wq;
    logic [15:0] si;
    logic [15:0] sq;
    logic [15:0] qhold;
    logic [6:0] cnt;
    logic half;
    logic pready;
    logic pslverr;
    logic [31:0] rdata;
    tgf_word_t word;
  } tgf_state_t;
endpackage : tgf_pkg

/* tgf_sink.sv */
// Purpose: downstream capture of output words and strobe activity
// Assumes: word_out settles after each rising pclk edge
// Notes: marker splits interleaved words into in-phase and quadrature halves
`timescale 1ns/1ps
module tgf_sink (
  input wire logic pclk,
  input wire logic clr,
  input wire tgf_pkg::tgf_word_t word,
  output int high_cnt,
  output logic [15:0] first_i,
  output logic [15:0] second_i
);
  import tgf_pkg::*;
  // count strobe-high cycles; the bench reads the count over a fixed window
  always_ff @(posedge pclk) begin
    if (clr) begin
      high_cnt <= 0;
    end else if (word.strobe) begin
      high_cnt <= high_cnt + 1;
    end
    // split the shared port by marker, as a real capture register would
    if (word.marker) begin
      first_i <= word.i;
    end else begin
      second_i <= word.i;
    end
  end
endmodule : tgf_sink

/* tgf_top.sv */
// Purpose: gain scaling, rounding and word formatting of tuner output samples
// Assumes: samples arrive on pclk from the filter; sync pin is asynchronous
// Notes: apb slave with one wait state; all outputs come from the state register
`timescale 1ns/1ps
`include "tgf_cfg.svh"
module tgf_top #(
  parameter int AW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tgf_pkg::tgf_sample_t sample_in,
  input wire logic gain_sync_pin_n,
  output tgf_pkg::tgf_word_t word_out,
  output logic clock_loss_detect_off
);
  import tgf_pkg::*;

  tgf_state_t st;
  tgf_state_t n;
  logic acc;
  logic wr;
  logic wr_man;
  logic wr_pow;
  logic apply;
  logic ilv;
  logic [2:0] ex;
  logic [7:0] period;
  logic [3:0] idx;
  logic mapped;

  // byte address to register index; misaligned or out of range gives 4'hf
  function automatic logic [3:0] reg_index(input logic [AW-1:0] a);
    logic [3:0] r;
    r = 4'hf;
    if (a[1:0] == 2'h0 && a[AW-1:6] == '0) begin
      r = a[5:2];
    end
    return r;
  endfunction : reg_index

  // base shift from rate setting: 6 for 0 or 1, then one less per step
  function automatic logic [2:0] base_shift(input logic [2:0] rate);
    return (rate <= 3'h1) ? `TGF_BASE_MAX : 3'(3'h7 - rate); // [RULE4]
  endfunction : base_shift

  // wide product keeps four guard bits below the 16-bit output lsb
  function automatic logic signed [39:0] scale(
    input logic signed [11:0] x,
    input logic [7:0] f,
    input logic [3:0] s,
    input logic [2:0] b
  );
    logic signed [39:0] m;
    m = 40'($signed({2'b01, f})); // one plus f/256 [RULE3]
    return ((40'(x) * m) <<< s) >>> b; // [RULE3] [RULE5]
  endfunction : scale

  // round to the narrowest selected width, saturate, clear the lsbs
  function automatic logic [15:0] round_word(
    input logic signed [39:0] w,
    input logic [3:0] sel
  );
    logic signed [39:0] t;
    logic signed [39:0] lim;
    int k;
    k = `TGF_GUARD; // nothing selected falls back to full width
    if (sel[0]) begin
      k = `TGF_GUARD + 6; // round_ten [RULE19] [RULE24]
    end else if (sel[1]) begin
      k = `TGF_GUARD + 4; // round_twelve [RULE19]
    end else if (sel[2]) begin
      k = `TGF_GUARD + 2; // round_fourteen [RULE19]
    end
    t = (w + (40'sd1 <<< (k - 1))) >>> k;
    lim = 40'sd1 <<< (`TGF_OUT_W + `TGF_GUARD - 1 - k);
    // clip after rounding so a carry into the sign bit cannot wrap
    if (t >= lim) begin
      t = lim - 40'sd1; // [RULE23]
    end else if (t < -lim) begin
      t = -lim; // [RULE23]
    end
    return 16'(t <<< (k - `TGF_GUARD)); // low bits shift in as zero [RULE20]
  endfunction : round_word

  // next state of the whole block
  always_comb begin
    n = st;
    idx = reg_index(paddr);
    mapped = idx >= `TGF_IDX_MODE && idx <= `TGF_IDX_FMT;
    acc = psel & penable & st.pready;
    wr = acc & pwrite & mapped;
    wr_man = wr && idx == `TGF_IDX_MAN;
    wr_pow = wr && idx == `TGF_IDX_POW;
    // one wait state: pready rises the cycle after the access phase opens
    n.pready = psel & penable & ~st.pready;
    n.pslverr = psel & penable & ~st.pready & ~mapped;
    n.rdata = 32'h0;
    case (idx)
      `TGF_IDX_MODE: n.rdata[7:0] = {3'h0, st.real_out, 1'b0, st.rate};
      `TGF_IDX_MAN: n.rdata[7:0] = st.man; // [RULE1]
      `TGF_IDX_POW: n.rdata[7:0] = {2'h0, st.ckoff, st.gs_sel, st.pow}; // [RULE25]
      `TGF_IDX_FMT: n.rdata[7:0] = st.fmt;
      default: n.rdata = 32'h0;
    endcase
    if (!(psel & penable & ~st.pready)) begin
      n.rdata = st.rdata;
    end
    // register writes take effect on the edge that completes the access
    if (wr_man) begin
      n.man = pwdata[7:0]; // [RULE1]
    end
    if (wr_pow) begin
      n.pow = pwdata[3:0]; // [RULE2]
      n.gs_sel = pwdata[`TGF_GS_BIT];
      n.ckoff = pwdata[`TGF_CKOFF_BIT]; // [RULE10]
    end
    if (wr && idx == `TGF_IDX_FMT) begin
      n.fmt = pwdata[7:0];
    end
    if (wr && idx == `TGF_IDX_MODE) begin
      n.rate = pwdata[2:0];
      n.real_out = pwdata[`TGF_REAL_BIT]; // [RULE22]
    end
    // sync pin: first flop feeds only the second
    n.sync1 = gain_sync_pin_n;
    n.sync2 = st.sync1;
    // pending pair moves to the active copy now, or on sync pin low
    apply = st.pend & (~st.gs_sel | ~st.sync2); // [RULE7] [RULE8]
    if (apply) begin
      n.act_man = st.man; // [RULE6]
      n.act_pow = st.pow; // [RULE6]
      n.pend = 1'b0;
    end
    // a new exponent write wins over the clear of the same cycle
    if (wr_pow) begin
      n.pend = 1'b1; // [RULE6]
    end
    // gain stage, then rounding stage
    if (sample_in.valid) begin
      n.wi = scale(sample_in.i, st.act_man, st.act_pow, base_shift(st.rate));
      n.wq = scale(sample_in.q, st.act_man, st.act_pow, base_shift(st.rate));
    end
    n.si = round_word(st.wi, st.fmt[`TGF_RND_LSB +: 4]); // [RULE19]
    n.sq = round_word(st.wq, st.fmt[`TGF_RND_LSB +: 4]);
    // word period: complex rate, twice as fast for real from rate 2 up, halved again interleaved
    ilv = st.fmt[`TGF_ILV_BIT] & ~st.real_out; // [RULE22]
    if (st.real_out) begin
      ex = (st.rate <= 3'h2) ? 3'h0 : 3'(st.rate - 3'h2);
    end else begin
      ex = (st.rate <= 3'h1) ? 3'h0 : 3'(st.rate - 3'h1);
    end
    // at full clock rate there is no room to halve; pairs then take two clocks
    if (ilv && ex != 3'h0) begin
      ex = 3'(ex - 3'h1); // [RULE13]
    end
    period = 8'h1 << ex;
    if (st.cnt == 7'h0 || {1'b0, st.cnt} >= period) begin
      n.cnt = 7'(period - 8'h1);
    end else begin
      n.cnt = 7'(st.cnt - 7'h1);
    end
    // output word transition when the period counter wraps
    if (st.cnt == 7'h0) begin
      if (ilv && !st.half) begin
        n.word.i = st.si; // [RULE12]
        n.word.q = 16'h0; // [RULE15]
        n.word.marker = 1'b1; // [RULE14]
        n.qhold = st.sq;
        n.half = 1'b1;
      end else if (ilv) begin
        n.word.i = st.qhold; // [RULE12]
        n.word.q = 16'h0; // [RULE15]
        n.word.marker = 1'b0; // [RULE14]
        n.half = 1'b0;
      end else begin
        n.word.i = st.si; // [RULE11]
        n.word.q = st.real_out ? 16'h0 : st.sq; // [RULE11] [RULE22]
        n.word.marker = 1'b0;
        n.half = 1'b0;
      end
    end
    // strobe from the counter that will stand in the next cycle
    if (st.fmt[`TGF_STY_BIT]) begin
      n.word.strobe = {n.cnt, 1'b0} < period; // [RULE18]
    end else begin
      n.word.strobe = n.cnt == 7'h0; // [RULE17]
    end
    n.word.strobe = n.word.strobe ^ st.fmt[`TGF_POL_BIT]; // [RULE16]
  end

  // one register for all state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.man <= `TGF_MAN_RST;
      st.pow <= 4'(`TGF_POW_RST);
      st.act_pow <= 4'(`TGF_POW_RST);
      st.ckoff <= 1'(`TGF_POW_RST >> `TGF_CKOFF_BIT); // [RULE10]
      st.fmt <= `TGF_FMT_RST;
      st.rate <= 3'(`TGF_MODE_RST);
      st.sync1 <= 1'b1;
      st.sync2 <= 1'b1;
    end else begin
      st <= n;
    end
  end

  // outputs straight from the state register
  assign prdata = st.rdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign word_out = st.word;
  assign clock_loss_detect_off = st.ckoff;

  // checks on gain buffering and power register read
  property p_apply_now;
    @(posedge pclk) disable iff (!presetn)
    (wr_pow && !pwdata[`TGF_GS_BIT]) |-> ##2 (st.act_pow == $past(pwdata[3:0], 2));
  endproperty
  a_apply_now: assert property (p_apply_now) else $error("gain not applied"); // [RULE7]

  property p_hold_sync;
    @(posedge pclk) disable iff (!presetn)
    (st.pend && st.gs_sel && st.sync2) |=> $stable(st.act_pow) && $stable(st.act_man);
  endproperty
  a_hold_sync: assert property (p_hold_sync) else $error("gain applied early"); // [RULE8]

  property p_man_alone;
    @(posedge pclk) disable iff (!presetn)
    (wr_man && !st.pend) |=> $stable(st.act_man);
  endproperty
  a_man_alone: assert property (p_man_alone) else $error("mantissa applied alone"); // [RULE6]

  property p_pow_read;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !st.pready && !pwrite && idx == `TGF_IDX_POW)
      |=> (st.rdata[31:6] == 26'h0) && (st.rdata[3:0] == st.pow);
  endproperty
  a_pow_read: assert property (p_pow_read) else $error("power read wrong"); // [RULE25]

  // checks on output formatting
  property p_q_low;
    @(posedge pclk) disable iff (!presetn)
    (st.word.marker || st.half) |-> st.word.q == 16'h0;
  endproperty
  a_q_low: assert property (p_q_low) else $error("quadrature port not low"); // [RULE15]

  property p_pair;
    @(posedge pclk) disable iff (!presetn)
    (st.word.marker && st.cnt == 7'h0 && $stable(st.fmt) && st.fmt[`TGF_ILV_BIT] && !st.real_out)
      |=> !st.word.marker && st.word.i == $past(st.qhold);
  endproperty
  a_pair: assert property (p_pair) else $error("pair order broken"); // [RULE12]

  property p_pulse;
    @(posedge pclk) disable iff (!presetn)
    (!st.fmt[`TGF_STY_BIT] && $stable(st.fmt) && $past(presetn))
      |-> ((st.word.strobe ^ st.fmt[`TGF_POL_BIT]) == (st.cnt == 7'h0));
  endproperty
  a_pulse: assert property (p_pulse) else $error("strobe pulse misplaced"); // [RULE17]

  property p_low_zero;
    @(posedge pclk) disable iff (!presetn)
    st.fmt[`TGF_RND_LSB] |=> st.si[5:0] == 6'h0;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low bits not cleared"); // [RULE20]

  property p_sat;
    @(posedge pclk) disable iff (!presetn)
    (st.wi >= 40'sh80000 && st.fmt[7:4] == 4'h8) |=> st.si == 16'h7fff;
  endproperty
  a_sat: assert property (p_sat) else $error("no saturation"); // [RULE23]

  // main scenarios
  c_ilv: cover property (@(posedge pclk) disable iff (!presetn) st.word.marker ##1 st.half);
  c_sync: cover property (@(posedge pclk) disable iff (!presetn) st.pend && st.gs_sel ##1 !st.pend);
  c_clock: cover property (@(posedge pclk) disable iff (!presetn)
    st.fmt[`TGF_STY_BIT] && $rose(st.word.strobe));
  c_sat: cover property (@(posedge pclk) disable iff (!presetn) st.si == 16'h7fff);
endmodule : tgf_top
